/* File: rtl/ebr_pkg.sv */
package ebr_pkg;

    // storage of one block: data bits usable by the ram modes, and all bits with parity
    localparam int EBR_DATA_BITS    = 8192;
    localparam int EBR_TOTAL_BITS   = 9216;
    localparam int EBR_MAX_PORT_W   = 36;
    // mixed-width limits in simple dual-port mode
    localparam int EBR_MAX_SDP_RD_W = 8;
    localparam int EBR_MAX_SDP_WR_W = 32;

    // default shapes
    localparam int EBR_WA           = 8;
    localparam int EBR_WB           = 8;
    localparam bit EBR_OUT_REG      = 1'b0;
    localparam int EBR_SR_W         = 8;
    localparam int EBR_SR_LEN       = 16;
    localparam int EBR_SR_TAPS      = 4;

    // values after reset
    localparam logic EBR_HOLD_RST   = 1'b0;

    typedef enum {
        EBR_SINGLE,
        EBR_SIMPLE_DP,
        EBR_TRUE_DP,
        EBR_SHIFT
    } ebr_mode_t;

    // address width of a port of the given data width
    function automatic int ebr_addr_w(input int w);
        return $clog2(EBR_DATA_BITS / w);
    endfunction

    // a width the array can serve without parity bits
    function automatic bit ebr_plain_w(input int w);
        return (w == 1) || (w == 2) || (w == 4) || (w == 8) || (w == 16) || (w == 32);
    endfunction

    // true when two bit ranges of the array share any bit
    function automatic bit ebr_overlap(input int a, input int wa, input int b, input int wb);
        return (a * wa < b * wb + wb) && (b * wb < a * wa + wa);
    endfunction

endpackage

/* File: rtl/ebr_if.sv */
`timescale 1ns/100ps
interface ebr_if
    import ebr_pkg::*;
#(
    parameter int WA      = EBR_WA,
    parameter int WB      = EBR_WB,
    parameter int SR_W    = EBR_SR_W,
    parameter int SR_TAPS = EBR_SR_TAPS
);
    localparam int AWA = ebr_addr_w(WA);
    localparam int AWB = ebr_addr_w(WB);

    logic [AWA-1:0]          a_addr;
    logic                    a_hold;
    logic                    a_we;
    logic [WA-1:0]           a_wdata;
    logic [WA-1:0]           a_q;
    logic [AWB-1:0]          b_addr;
    logic                    b_hold;
    logic                    b_we;
    logic [WB-1:0]           b_wdata;
    logic [WB-1:0]           b_q;
    logic [SR_W-1:0]         sr_in;
    logic [SR_TAPS*SR_W-1:0] sr_taps;
    logic [SR_W-1:0]         sr_tail;

    modport ram (
        input  a_addr, a_hold, a_we, a_wdata,
        input  b_addr, b_hold, b_we, b_wdata,
        input  sr_in,
        output a_q, b_q, sr_taps, sr_tail
    );

    modport user (
        output a_addr, a_hold, a_we, a_wdata,
        output b_addr, b_hold, b_we, b_wdata,
        output sr_in,
        input  a_q, b_q, sr_taps, sr_tail
    );

endinterface // ebr_if

/* File: rtl/ebr_user_port.sv */
`timescale 1ns/100ps
module ebr_user_port
    import ebr_pkg::*;
#(
    parameter ebr_mode_t MODE    = EBR_TRUE_DP,
    parameter int        WA      = EBR_WA,
    parameter int        WB      = EBR_WB,
    parameter int        SR_W    = EBR_SR_W,
    parameter int        SR_TAPS = EBR_SR_TAPS
) (
    // clock and reset
    input  wire logic                    I_SYS_CLK,
    input  wire logic                    I_ARST_N,
    // port a requests
    input  wire logic [ebr_addr_w(WA)-1:0] I_A_ADDR,
    input  wire logic                    I_A_HOLD,
    input  wire logic                    I_A_WE,
    input  wire logic [WA-1:0]           I_A_WDATA,
    // port b requests
    input  wire logic [ebr_addr_w(WB)-1:0] I_B_ADDR,
    input  wire logic                    I_B_HOLD,
    input  wire logic                    I_B_WE,
    input  wire logic [WB-1:0]           I_B_WDATA,
    // shift line input
    input  wire logic [SR_W-1:0]         I_SR_IN,
    // read data and taps
    output logic      [WA-1:0]           O_A_Q,
    output logic      [WB-1:0]           O_B_Q,
    output logic      [SR_TAPS*SR_W-1:0] O_SR_TAPS,
    output logic      [SR_W-1:0]         O_SR_TAIL,
    // status
    output logic                         O_COLLISION,
    // memory side
    ebr_if.user                          BUS
);
    localparam int AWA = ebr_addr_w(WA);
    localparam int AWB = ebr_addr_w(WB);

    logic [AWA-1:0] mir_a_q;
    logic [AWA-1:0] mir_a_d;
    logic [AWB-1:0] mir_b_q;
    logic [AWB-1:0] mir_b_d;
    logic           clash;
    logic           coll_q;
    logic           coll_d;

    // mirror the block's address registers so clashes are judged on held addresses
    always_comb begin
        mir_a_d = I_A_HOLD ? mir_a_q : I_A_ADDR;
        mir_b_d = I_B_HOLD ? mir_b_q : I_B_ADDR;
        clash   = (MODE == EBR_TRUE_DP) && I_A_WE && I_B_WE &&
                  ebr_overlap(int'(mir_a_d), WA, int'(mir_b_d), WB);
        coll_d  = clash;
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            mir_a_q <= '0;
            mir_b_q <= '0;
            coll_q  <= 1'b0;
        end else begin
            mir_a_q <= mir_a_d;
            mir_b_q <= mir_b_d;
            coll_q  <= coll_d;
        end
    end

    assign BUS.a_addr  = I_A_ADDR;
    assign BUS.a_hold  = I_A_HOLD;
    assign BUS.a_we    = I_A_WE;
    assign BUS.a_wdata = I_A_WDATA;
    assign BUS.b_addr  = I_B_ADDR;
    assign BUS.b_hold  = I_B_HOLD;
    // port a wins; the losing write is dropped rather than corrupting the word
    assign BUS.b_we    = I_B_WE && !clash;
    assign BUS.b_wdata = I_B_WDATA;
    assign BUS.sr_in   = I_SR_IN;

    assign O_A_Q       = BUS.a_q;
    assign O_B_Q       = BUS.b_q;
    assign O_SR_TAPS   = BUS.sr_taps;
    assign O_SR_TAIL   = BUS.sr_tail;
    assign O_COLLISION = coll_q;

endmodule // ebr_user_port

/* File: rtl/ebr_ram_block.sv */
// What this block does
// - hold input high keeps address register
// - hold muxes register output back in
// - each port has own hold
// - hold low by default, loads normally
// - output register adds exactly one cycle
// - simple dual-port: write and read together
// - read/write or input/output clocking, both on the one system clock
// - mixed widths, no parity write shapes
// - true dual-port: both ports access anything
// - no arbitration for same-address double write
// - user logic prevents same-address double writes
// - shift size within total block storage
// - width times taps within port width
// - larger shifters cascade tail into next
`timescale 1ns/100ps
module ebr_ram_block
    import ebr_pkg::*;
#(
    parameter ebr_mode_t MODE    = EBR_TRUE_DP,
    parameter int        WA      = EBR_WA,
    parameter int        WB      = EBR_WB,
    parameter bit        OUT_REG = EBR_OUT_REG,
    parameter int        SR_W    = EBR_SR_W,
    parameter int        SR_LEN  = EBR_SR_LEN,
    parameter int        SR_TAPS = EBR_SR_TAPS
) (
    // clock and reset
    input  wire logic I_SYS_CLK,
    input  wire logic I_ARST_N,
    // user side
    ebr_if.ram        BUS
);
    localparam int AWA = ebr_addr_w(WA);
    localparam int AWB = ebr_addr_w(WB);
    localparam int PW  = $clog2(SR_LEN);

    // elaboration checks
    if (!ebr_plain_w(WA) || !ebr_plain_w(WB)) begin : g_bad_w
        $error("port widths must be 1, 2, 4, 8, 16 or 32");
    end
    if (MODE == EBR_SIMPLE_DP && WB > EBR_MAX_SDP_RD_W) begin : g_bad_rd
        $error("simple dual-port read port wider than allowed");
    end
    if (MODE == EBR_SIMPLE_DP && WA > EBR_MAX_SDP_WR_W) begin : g_bad_wr
        $error("simple dual-port write port wider than allowed");
    end
    if (MODE == EBR_SHIFT && SR_W * SR_LEN * SR_TAPS > EBR_TOTAL_BITS) begin : g_bad_sz
        $error("shift register larger than block storage");
    end
    if (MODE == EBR_SHIFT && SR_W * SR_TAPS > EBR_MAX_PORT_W) begin : g_bad_tw
        $error("shift register taps wider than block port");
    end
    if (SR_LEN < 2) begin : g_bad_len
        $error("tap length must be at least 2");
    end

    // array; no reset, contents are undefined until written
    logic mem [EBR_TOTAL_BITS];

    // address registers
    logic [AWA-1:0] addr_a_q;
    logic [AWA-1:0] addr_a_d;
    logic [AWB-1:0] addr_b_q;
    logic [AWB-1:0] addr_b_d;
    logic           we_a;
    logic           we_b;

    always_comb begin
        addr_a_d = BUS.a_hold ? addr_a_q : BUS.a_addr;
        addr_b_d = BUS.b_hold ? addr_b_q : BUS.b_addr;
        we_a     = BUS.a_we && (MODE != EBR_SHIFT);
        we_b     = BUS.b_we && (MODE == EBR_TRUE_DP);
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            addr_a_q <= '0;
            addr_b_q <= '0;
        end else begin
            addr_a_q <= addr_a_d;
            addr_b_q <= addr_b_d;
        end
    end

    // shift line state
    logic [PW-1:0]   ptr_q;
    logic [PW-1:0]   ptr_d;
    logic [SR_W-1:0] old_w    [SR_TAPS];
    logic [SR_W-1:0] line_in  [SR_TAPS];
    logic [SR_W-1:0] taps_q   [SR_TAPS];
    logic [SR_W-1:0] taps_d   [SR_TAPS];

    always_comb begin
        ptr_d = (int'(ptr_q) == SR_LEN - 1) ? '0 : ptr_q + 1'b1;
        for (int k = 0; k < SR_TAPS; k++) begin
            for (int b = 0; b < SR_W; b++) begin
                old_w[k][b] = mem[(k * SR_LEN + int'(ptr_q)) * SR_W + b];
            end
            // line 0 feeds on the shift input; each later line on the previous line's oldest word
            line_in[k] = (k == 0) ? BUS.sr_in : old_w[(k == 0) ? 0 : k - 1];
            taps_d[k]  = old_w[k];
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ptr_q <= '0;
            for (int k = 0; k < SR_TAPS; k++) begin
                taps_q[k] <= '0;
            end
        end else begin
            ptr_q <= ptr_d;
            for (int k = 0; k < SR_TAPS; k++) begin
                taps_q[k] <= taps_d[k];
            end
        end
    end

    // array writes
    always_ff @(posedge I_SYS_CLK) begin
        if (MODE == EBR_SHIFT) begin
            for (int k = 0; k < SR_TAPS; k++) begin
                for (int b = 0; b < SR_W; b++) begin
                    mem[(k * SR_LEN + int'(ptr_q)) * SR_W + b] <= line_in[k][b];
                end
            end
        end else begin
            if (we_a) begin
                for (int b = 0; b < WA; b++) begin
                    mem[int'(addr_a_d) * WA + b] <= BUS.a_wdata[b];
                end
            end
            if (we_b) begin
                for (int b = 0; b < WB; b++) begin
                    mem[int'(addr_b_d) * WB + b] <= BUS.b_wdata[b];
                end
            end
        end
    end

    // read path: array read from the registered address
    logic [WA-1:0] rd_a;
    logic [WB-1:0] rd_b;
    logic [WA-1:0] q_a_q;
    logic [WA-1:0] q_a_d;
    logic [WB-1:0] q_b_q;
    logic [WB-1:0] q_b_d;

    always_comb begin
        rd_a = '0;
        rd_b = '0;
        for (int b = 0; b < WA; b++) begin
            rd_a[b] = mem[int'(addr_a_q) * WA + b];
        end
        for (int b = 0; b < WB; b++) begin
            rd_b[b] = mem[int'(addr_b_q) * WB + b];
        end
        // port a only writes in simple dual-port; b is idle in single-port
        if (MODE == EBR_SIMPLE_DP || MODE == EBR_SHIFT) begin
            rd_a = '0;
        end
        if (MODE == EBR_SINGLE || MODE == EBR_SHIFT) begin
            rd_b = '0;
        end
        q_a_d = rd_a;
        q_b_d = rd_b;
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            q_a_q <= '0;
            q_b_q <= '0;
        end else begin
            q_a_q <= q_a_d;
            q_b_q <= q_b_d;
        end
    end

    assign BUS.a_q = OUT_REG ? q_a_q : rd_a;
    assign BUS.b_q = OUT_REG ? q_b_q : rd_b;

    // one clock serves both
    // both clocking arrangements collapse onto the single system clock here;
    // a split-clock build would need a crossing on the read side.

    // taps flattened, tap 0 in the low bits
    for (genvar k = 0; k < SR_TAPS; k++) begin : g_taps
        assign BUS.sr_taps[k*SR_W +: SR_W] = taps_q[k];
    end
    assign BUS.sr_tail = taps_q[SR_TAPS-1];

endmodule // ebr_ram_block

/* File: sim/ebr_properties.sv */
`timescale 1ns/100ps
module ebr_properties
    import ebr_pkg::*;
#(
    parameter int WA = EBR_WA,
    parameter int WB = EBR_WB
) (
    // clock and reset
    input wire logic                      I_SYS_CLK,
    input wire logic                      I_ARST_N,
    // port a
    input wire logic [ebr_addr_w(WA)-1:0] a_addr,
    input wire logic                      a_hold,
    input wire logic                      a_we,
    input wire logic [WA-1:0]             a_wdata,
    input wire logic [WA-1:0]             a_q,
    // port b
    input wire logic [ebr_addr_w(WB)-1:0] b_addr,
    input wire logic                      b_hold,
    input wire logic                      b_we,
    input wire logic [WB-1:0]             b_wdata,
    input wire logic [WB-1:0]             b_q
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_ARST_N);

    // written for unregistered read data only
    a_hold_keeps_a: assert property (a_hold && !a_we && !b_we |=> $stable(a_q))
        else $error("port a read data moved while held");
    b_hold_keeps_a: assert property (b_hold && !a_we && !b_we |=> $stable(b_q))
        else $error("port b read data moved while held");
    held_write_lands_a: assert property (a_hold && a_we && !b_we |=> a_q == $past(a_wdata))
        else $error("write through held address lost");
    a_write_read_a: assert property (a_we && !a_hold && !b_we |=> a_q == $past(a_wdata))
        else $error("port a write not read back");
    cross_read_a: assert property (a_we && !a_hold && !b_hold && !b_we && b_addr == a_addr
        |=> b_q == $past(a_wdata))
        else $error("port b missed port a write");
    b_write_read_a: assert property (b_we && !b_hold && !a_we |=> b_q == $past(b_wdata))
        else $error("port b write not read back");
    // port b may legally write the word that port a holds, so a_q may take that data
    hold_isolated_a: assert property (a_hold && !a_we && b_we && !b_hold
        |=> b_q == $past(b_wdata) && ($stable(a_q) || a_q == $past(b_wdata)))
        else $error("port a hold disturbed port b");
    no_double_write_a: assert property (a_we && b_we && !a_hold && !b_hold
        |-> a_addr != b_addr)
        else $error("same word written by both ports");
endmodule // ebr_properties

/* File: sim/test_embedded_block_ram.sv */
`timescale 1ns/100ps
module test_embedded_block_ram
    import ebr_pkg::*;
;
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    logic [9:0] a_addr = '0;
    logic [9:0] b_addr = '0;
    logic       a_hold = 1'b0;
    logic       b_hold = 1'b0;
    logic       a_we = 1'b0;
    logic       b_we = 1'b0;
    logic [7:0] a_wd = '0;
    logic [7:0] b_wd = '0;
    logic [7:0] a_q;
    logic [7:0] b_q;
    logic       coll;
    logic [15:0] sdp_a_q;
    logic [7:0]  sdp_b_q;
    logic [7:0]  sr_in = '0;
    logic [15:0] sr_taps;
    logic [7:0]  sr_tail;
    int         err_count = 0;
    int         total_checks = 0;

    always #10 clk = ~clk;

    ebr_if ebr_if_inst ();
    ebr_ram_block #(.MODE(EBR_TRUE_DP), .OUT_REG(1'b0)) ebr_ram_block_inst (
        .I_SYS_CLK(clk), .I_ARST_N(arst_n), .BUS(ebr_if_inst.ram));
    ebr_user_port #(.MODE(EBR_TRUE_DP)) ebr_user_port_inst (
        .I_SYS_CLK(clk), .I_ARST_N(arst_n),
        .I_A_ADDR(a_addr), .I_A_HOLD(a_hold), .I_A_WE(a_we), .I_A_WDATA(a_wd),
        .I_B_ADDR(b_addr), .I_B_HOLD(b_hold), .I_B_WE(b_we), .I_B_WDATA(b_wd),
        .I_SR_IN(8'h00), .O_A_Q(a_q), .O_B_Q(b_q), .O_SR_TAPS(), .O_SR_TAIL(),
        .O_COLLISION(coll), .BUS(ebr_if_inst.user));
    ebr_properties ebr_properties_inst (
        .I_SYS_CLK(clk), .I_ARST_N(arst_n),
        .a_addr(ebr_if_inst.a_addr), .a_hold(ebr_if_inst.a_hold), .a_we(ebr_if_inst.a_we),
        .a_wdata(ebr_if_inst.a_wdata), .a_q(ebr_if_inst.a_q),
        .b_addr(ebr_if_inst.b_addr), .b_hold(ebr_if_inst.b_hold), .b_we(ebr_if_inst.b_we),
        .b_wdata(ebr_if_inst.b_wdata), .b_q(ebr_if_inst.b_q));

    // mixed-width simple dual-port on the one clock, registered reads
    ebr_if #(.WA(16), .WB(8)) ebr_if_sdp_inst ();
    ebr_ram_block #(.MODE(EBR_SIMPLE_DP), .WA(16), .WB(8), .OUT_REG(1'b1))
        ebr_ram_block_sdp_inst (
        .I_SYS_CLK(clk), .I_ARST_N(arst_n), .BUS(ebr_if_sdp_inst.ram));
    ebr_user_port #(.MODE(EBR_SIMPLE_DP), .WA(16), .WB(8)) ebr_user_port_sdp_inst (
        .I_SYS_CLK(clk), .I_ARST_N(arst_n),
        .I_A_ADDR(a_addr[8:0]), .I_A_HOLD(a_hold), .I_A_WE(a_we), .I_A_WDATA({b_wd, a_wd}),
        .I_B_ADDR(b_addr), .I_B_HOLD(b_hold), .I_B_WE(b_we), .I_B_WDATA(b_wd),
        .I_SR_IN(8'h00), .O_A_Q(sdp_a_q), .O_B_Q(sdp_b_q), .O_SR_TAPS(), .O_SR_TAIL(),
        .O_COLLISION(), .BUS(ebr_if_sdp_inst.user));

    // 8 x 2 x 2 bits fit the block
    // 8 x 2 taps fit the port
    ebr_if #(.SR_W(8), .SR_TAPS(2)) ebr_if_sr_inst ();
    ebr_ram_block #(.MODE(EBR_SHIFT), .SR_W(8), .SR_LEN(2), .SR_TAPS(2))
        ebr_ram_block_sr_inst (
        .I_SYS_CLK(clk), .I_ARST_N(arst_n), .BUS(ebr_if_sr_inst.ram));
    ebr_user_port #(.MODE(EBR_SHIFT), .SR_W(8), .SR_TAPS(2)) ebr_user_port_sr_inst (
        .I_SYS_CLK(clk), .I_ARST_N(arst_n),
        .I_A_ADDR(a_addr), .I_A_HOLD(a_hold), .I_A_WE(a_we), .I_A_WDATA(a_wd),
        .I_B_ADDR(b_addr), .I_B_HOLD(b_hold), .I_B_WE(b_we), .I_B_WDATA(b_wd),
        .I_SR_IN(sr_in), .O_A_Q(), .O_B_Q(), .O_SR_TAPS(sr_taps), .O_SR_TAIL(sr_tail),
        .O_COLLISION(), .BUS(ebr_if_sr_inst.user));

    task automatic finish_test();
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one cycle: inputs set at the falling edge, results settled one falling edge later
    task automatic cy(input logic [9:0] aa, input logic ah, input logic aw, input logic [7:0] ad,
                      input logic [9:0] ba, input logic bh, input logic bw, input logic [7:0] bd);
        a_addr = aa;
        a_hold = ah;
        a_we = aw;
        a_wd = ad;
        b_addr = ba;
        b_hold = bh;
        b_we = bw;
        b_wd = bd;
        @(negedge clk);
    endtask

    initial begin
        #20000;
        err_count++;
        finish_test();
    end

    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        // hold left low, each address loads
        for (int i = 0; i < 4; i++) begin
            cy(10'(i), 0, 1, 8'h10 + 8'(i), 10'(i), 0, 0, 8'h00);
            chk(a_q, 8'h10 + 8'(i)); // fresh address
            chk(b_q, 8'h10 + 8'(i)); // seen from port b
        end
        cy(10'd2, 0, 0, 8'h00, 10'd3, 0, 0, 8'h00);
        cy(10'd3, 1, 0, 8'h00, 10'd1, 0, 0, 8'h00);
        chk(a_q, 8'h12); // held word
        chk(b_q, 8'h11); // other port loads
        cy(10'd2, 0, 0, 8'h00, 10'd0, 1, 0, 8'h00);
        chk(a_q, 8'h12); // other port loads
        chk(b_q, 8'h11); // port b held
        cy(10'd5, 1, 1, 8'h55, 10'd2, 0, 0, 8'h00);
        chk(a_q, 8'h55); // write to held address
        chk(b_q, 8'h55); // same word via b
        // colliding writes: port a must win
        cy(10'd7, 0, 1, 8'haa, 10'd7, 0, 1, 8'hbb);
        chk({7'h00, coll}, 8'h01); // drop flagged
        cy(10'd7, 0, 0, 8'h00, 10'd7, 0, 0, 8'h00);
        chk(b_q, 8'haa); // port a data kept
        chk({7'h00, coll}, 8'h00); // pulse is one cycle
        cy(10'd8, 0, 1, 8'h81, 10'd9, 0, 1, 8'h92);
        chk(a_q, 8'h81); // both writes taken
        chk(b_q, 8'h92); // both writes taken
        chk({7'h00, coll}, 8'h00); // no false drop
        cy(10'd9, 0, 0, 8'h00, 10'd8, 0, 0, 8'h00);
        chk(a_q, 8'h92); // cross read
        chk(b_q, 8'h81); // cross read
        cy(10'd3, 1, 0, 8'h00, 10'd4, 0, 1, 8'h44);
        chk(a_q, 8'h92); // hold unaffected by b
        chk(b_q, 8'h44); // b writes freely
        // idle edge lets the last assertions finish their consequents
        cy(10'd0, 0, 0, 8'h00, 10'd0, 0, 0, 8'h00);
        // simple dual-port: 16-bit writes on a, byte reads on b, q one cycle late
        cy(10'd3, 0, 1, 8'h3c, 10'd0, 0, 0, 8'hc3);
        cy(10'd4, 0, 1, 8'h5a, 10'd6, 0, 0, 8'ha5);
        cy(10'd5, 0, 0, 8'h00, 10'd9, 0, 1, 8'hff);
        chk(sdp_b_q, 8'h3c); // low byte one cycle late
        cy(10'd5, 1, 0, 8'h00, 10'd9, 1, 0, 8'h00);
        chk(sdp_b_q, 8'ha5); // high byte, b write refused
        chk(sdp_a_q[7:0], 8'h00); // write port reads zero
        chk(sdp_a_q[15:8], 8'h00); // write port reads zero
        cy(10'd0, 0, 0, 8'h00, 10'd0, 0, 0, 8'h00);
        // shift line: tap0 lags the input by two edges, tap1 by four
        for (int j = 0; j < 8; j++) begin
            sr_in = 8'h20 + 8'(j);
            @(negedge clk);
            if (j >= 4) begin
                chk(sr_taps[7:0], 8'h20 + 8'(j - 2)); // tap0 lags two
                chk(sr_taps[15:8], 8'h20 + 8'(j - 4)); // tap1 lags four
                chk(sr_tail, 8'h20 + 8'(j - 4)); // tail is last tap
            end
        end
        finish_test();
    end
endmodule // test_embedded_block_ram
